/* File: mbs_server.sv */
`timescale 1ns/1ps
// Operation
// - Only reply to received requests, never initiate.
// - Serve up to eight open connections.
// - Accept requests only on port 502.
// - Data area is bytes, two per register.
// - Function 3 reads 40001-40161 instrument data; 40161 reads zero.
// - Instrument-data window is never written by master.
// - Functions 6, 16 store into 41025-41185; writes to 41185 dropped.
// - Function 3 reads back the output window.
// - Exchanged data area limited to 320 bytes.
// - Link lamp lit while network connected.
// - Status green 1 Hz if IP not from switches.
// - Status red 1 Hz, init abandoned, bad MAC.
// - Status red 2 Hz on flash config failure.
// - Status red 4 Hz on internal fault.
// - Activity lamp green, briefly off per packet.
// - Connection lamp blinks count, pauses, repeats.
module mbs_server
#(
   parameter int TICK_CYCLES = mbs_pkg::TICK_CYC
)
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire mbs_pkg::mbs_conn_t i_req_conn,
   input wire mbs_pkg::mbs_word_t i_req_port,
   input wire mbs_pkg::mbs_byte_t i_req_func,
   input wire mbs_pkg::mbs_word_t i_req_addr,
   input wire mbs_pkg::mbs_word_t i_req_qty,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire mbs_pkg::mbs_word_t i_wr_word,
   output logic o_rsp_valid,
   output mbs_pkg::mbs_conn_t o_rsp_conn,
   output mbs_pkg::mbs_byte_t o_rsp_func,
   output logic o_rsp_exc,
   output mbs_pkg::mbs_byte_t o_rsp_code,
   output mbs_pkg::mbs_word_t o_rsp_qty,
   output logic o_rd_valid,
   output mbs_pkg::mbs_word_t o_rd_word,
   input wire logic i_inst_we,
   input wire logic i_inst_re,
   input wire mbs_pkg::mbs_maddr_t i_inst_addr,
   input wire mbs_pkg::mbs_byte_t i_inst_wdata,
   output logic o_inst_rvalid,
   output mbs_pkg::mbs_byte_t o_inst_rdata,
   input wire logic [7:0] i_conn_est,
   input wire logic i_pkt_event,
   input wire logic i_eth_link,
   input wire logic i_ip_not_dip,
   input wire logic i_mac_bad,
   input wire logic i_flash_fail,
   input wire logic i_int_fault,
   output logic o_link_led,
   output logic o_stat_red,
   output logic o_stat_grn,
   output logic o_act_led,
   output logic o_conn_led,
   output logic o_init_abort
);
   import mbs_pkg::*;

   // ***************************************************************
   // Reset release
   // ***************************************************************
   logic [1:0] rst_ff;
   logic rst_n;

   // Async assert, release after two edges
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         rst_ff <= 2'h0;
      else
         rst_ff <= {rst_ff[0], 1'b1};
   end
   assign rst_n = rst_ff[1];

   default clocking @(posedge i_mclk); endclocking
   default disable iff (!rst_n);

   mbs_mem_if mif ();
   mbs_dpram #(.DEPTH(320), .LANES(2)) u_ram (.i_mclk(i_mclk), .i_ce(i_ce), .port(mif));

   // ***************************************************************
   // Request server
   // ***************************************************************
   mbs_st_t st_ff, nxt_st;
   mbs_conn_t conn_ff, nxt_conn;
   mbs_byte_t func_ff, nxt_func, code_ff, nxt_code;
   mbs_word_t addr_ff, nxt_addr, qty_ff, nxt_qty;
   logic win_ff, nxt_win, pend_ff, nxt_pend;
   logic [7:0] idx_ff, nxt_idx, cnt_ff, nxt_cnt;
   logic take, take_ok, in_ok, out_ok;
   logic [16:0] end_a;
   mbs_word_t rel;

   assign o_req_ready = (st_ff == ST_IDLE) && !i_mac_bad;
   assign take = i_req_valid && o_req_ready && i_ce;
   // Only the server port on an open connection is served
   assign take_ok = take && (i_req_port == SRV_PORT) && i_conn_est[i_req_conn];
   assign o_wr_ready = (st_ff == ST_WR);
   assign o_rsp_valid = (st_ff == ST_HDR);
   assign o_rsp_conn = conn_ff;
   assign o_rsp_func = func_ff;
   assign o_rsp_code = code_ff;
   assign o_rsp_exc = (code_ff != EXC_NONE);
   assign o_rsp_qty = qty_ff;

   // Window bounds, sum kept one bit wider to catch wrap
   always_comb
   begin
      end_a = {1'b0, addr_ff} + {1'b0, qty_ff};
      in_ok = (end_a <= {1'b0, IN_BASE + WIN_REGS});
      out_ok = (addr_ff >= OUT_BASE) && (end_a <= {1'b0, OUT_BASE + WIN_REGS});
   end

   // Next state of the server
   always_comb
   begin
      nxt_st = st_ff;
      nxt_conn = conn_ff;
      nxt_func = func_ff;
      nxt_addr = addr_ff;
      nxt_qty = qty_ff;
      nxt_code = code_ff;
      nxt_win = win_ff;
      nxt_idx = idx_ff;
      nxt_cnt = cnt_ff;
      nxt_pend = pend_ff;
      rel = 16'h0000;
      case (st_ff)
         ST_IDLE:
         begin
            if (take_ok)
            begin
               nxt_st = ST_CHK;
               nxt_conn = i_req_conn;
               nxt_func = i_req_func;
               nxt_addr = i_req_addr;
               nxt_qty = (i_req_func == FN_WR1) ? 16'h0001 : i_req_qty;
               nxt_pend = 1'b1;
            end
         end
         ST_CHK:
         begin
            nxt_code = EXC_NONE;
            nxt_win = 1'b0;
            case (func_ff)
               FN_RD:
               begin
                  if ((qty_ff == 16'h0000) || (qty_ff > MAX_RD_QTY))
                     nxt_code = EXC_VAL;
                  else if (out_ok)
                     nxt_win = 1'b1;
                  else if (!in_ok)
                     nxt_code = EXC_ADDR;
               end
               FN_WR1, FN_WRN:
               begin
                  nxt_win = 1'b1;
                  if ((qty_ff == 16'h0000) || (qty_ff > MAX_WR_QTY))
                     nxt_code = EXC_VAL;
                  else if (!out_ok)
                     nxt_code = EXC_ADDR;
               end
               default: nxt_code = EXC_FUNC;
            endcase
            rel = addr_ff - (nxt_win ? OUT_BASE : IN_BASE);
            nxt_idx = rel[7:0];
            nxt_cnt = qty_ff[7:0];
            if ((nxt_code == EXC_NONE) && (func_ff != FN_RD))
               nxt_st = ST_WR;
            else
               nxt_st = ST_HDR;
         end
         ST_HDR:
         begin
            nxt_pend = 1'b0;
            if ((code_ff == EXC_NONE) && (func_ff == FN_RD))
               nxt_st = ST_RD;
            else
               nxt_st = ST_IDLE;
         end
         ST_RD:
         begin
            nxt_idx = idx_ff + 8'h01;
            nxt_cnt = cnt_ff - 8'h01;
            if (cnt_ff == 8'h01)
               nxt_st = ST_IDLE;
         end
         ST_WR:
         begin
            if (i_wr_valid)
            begin
               nxt_idx = idx_ff + 8'h01;
               nxt_cnt = cnt_ff - 8'h01;
               if (cnt_ff == 8'h01)
                  nxt_st = ST_HDR;
            end
         end
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= ST_IDLE;
         conn_ff <= 3'h0;
         func_ff <= 8'h00;
         addr_ff <= 16'h0000;
         qty_ff <= 16'h0000;
         code_ff <= 8'h00;
         win_ff <= 1'b0;
         idx_ff <= 8'h00;
         cnt_ff <= 8'h00;
         pend_ff <= 1'b0;
      end
      else if (i_ce)
      begin
         st_ff <= nxt_st;
         conn_ff <= nxt_conn;
         func_ff <= nxt_func;
         addr_ff <= nxt_addr;
         qty_ff <= nxt_qty;
         code_ff <= nxt_code;
         win_ff <= nxt_win;
         idx_ff <= nxt_idx;
         cnt_ff <= nxt_cnt;
         pend_ff <= nxt_pend;
      end
   end

   // ***************************************************************
   // Data area ports
   // ***************************************************************
   logic beyond, rv1_ff, bz1_ff, rdv_ff, brv1_ff, lane1_ff, brv_ff, b_ok;
   mbs_word_t rdw_ff, nxt_rdw;
   mbs_byte_t brd_ff, nxt_brd;

   // Index 160 lies past the 320-byte area: reads zero, writes dropped
   assign beyond = ({1'b0, idx_ff} >= AREA_WORDS);
   assign mif.a_addr = win_ff ? AREA_WORDS + {1'b0, idx_ff} : {1'b0, idx_ff};
   assign mif.a_we = (st_ff == ST_WR) && i_wr_valid && !beyond;
   assign mif.a_be = 2'h3;
   assign mif.a_wdata = i_wr_word;
   // Instrument side: writes to input window, reads from output window
   assign b_ok = (i_inst_addr < DATA_BYTES);
   assign mif.b_we = i_inst_we && b_ok;
   assign mif.b_addr = i_inst_we ? {1'b0, i_inst_addr[8:1]} :
      AREA_WORDS + {1'b0, i_inst_addr[8:1]};
   assign mif.b_be = i_inst_addr[0] ? 2'h1 : 2'h2;
   assign mif.b_wdata = {i_inst_wdata, i_inst_wdata};
   assign nxt_rdw = bz1_ff ? 16'h0000 : mif.a_rdata;
   assign nxt_brd = lane1_ff ? mif.b_rdata[7:0] : mif.b_rdata[15:8];

   // Two-stage read pipelines toward the outputs
   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rv1_ff <= 1'b0;
         bz1_ff <= 1'b0;
         rdv_ff <= 1'b0;
         rdw_ff <= 16'h0000;
         brv1_ff <= 1'b0;
         lane1_ff <= 1'b0;
         brv_ff <= 1'b0;
         brd_ff <= 8'h00;
      end
      else if (i_ce)
      begin
         rv1_ff <= (st_ff == ST_RD);
         bz1_ff <= beyond;
         rdv_ff <= rv1_ff;
         rdw_ff <= nxt_rdw;
         brv1_ff <= i_inst_re && !i_inst_we && b_ok;
         lane1_ff <= i_inst_addr[0];
         brv_ff <= brv1_ff;
         brd_ff <= nxt_brd;
      end
   end
   assign o_rd_valid = rdv_ff;
   assign o_rd_word = rdw_ff;
   assign o_inst_rvalid = brv_ff;
   assign o_inst_rdata = brd_ff;

   // ***************************************************************
   // Indicator lamps
   // ***************************************************************
   logic [31:0] pre_ff, nxt_pre;
   logic [2:0] blink_ff, nxt_blink;
   logic [1:0] act_ff, nxt_act;
   logic [3:0] fl_ff, nxt_fl, pause_ff, nxt_pause, ncon;
   logic con_ff, nxt_con, lk1_ff, lk2_ff, red_ff, nxt_red, grn_ff, nxt_grn;
   logic tick, actl_ff, abort_ff;

   assign tick = (pre_ff == 32'(TICK_CYCLES - 1));
   assign ncon = 4'($countones(i_conn_est));

   // Blink phase: bit0 4 Hz, bit1 2 Hz, bit2 1 Hz
   always_comb
   begin
      nxt_pre = tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
      nxt_blink = blink_ff + {2'h0, tick};
      nxt_act = act_ff;
      if (i_pkt_event)
         nxt_act = ACT_OFF_TICKS;
      else if (tick && (act_ff != 2'h0))
         nxt_act = act_ff - 2'h1;
      nxt_red = 1'b0;
      nxt_grn = 1'b0;
      if (i_mac_bad)
         nxt_red = blink_ff[2];
      else if (i_flash_fail)
         nxt_red = blink_ff[1];
      else if (i_int_fault)
         nxt_red = blink_ff[0];
      else if (i_ip_not_dip)
         nxt_grn = blink_ff[2];
      else
         nxt_grn = 1'b1;
   end

   // Connection burst: one flash per link, then a 1 s gap
   always_comb
   begin
      nxt_fl = fl_ff;
      nxt_pause = pause_ff;
      nxt_con = con_ff;
      if (tick)
      begin
         if (pause_ff != 4'h0)
         begin
            nxt_pause = pause_ff - 4'h1;
            nxt_con = 1'b0;
         end
         else if (ncon == 4'h0)
         begin
            nxt_con = 1'b0;
            nxt_fl = 4'h0;
         end
         else if (con_ff)
         begin
            nxt_con = 1'b0;
            if ((fl_ff + 4'h1) >= ncon)
            begin
               nxt_fl = 4'h0;
               nxt_pause = CONN_PAUSE_TICKS;
            end
            else
               nxt_fl = fl_ff + 4'h1;
         end
         else
            nxt_con = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_ff <= 32'h0000_0000;
         blink_ff <= 3'h0;
         act_ff <= 2'h0;
         fl_ff <= 4'h0;
         pause_ff <= 4'h0;
         con_ff <= 1'b0;
         lk1_ff <= 1'b0;
         lk2_ff <= 1'b0;
         red_ff <= 1'b0;
         grn_ff <= 1'b0;
         actl_ff <= 1'b0;
         abort_ff <= 1'b0;
      end
      else if (i_ce)
      begin
         pre_ff <= nxt_pre;
         blink_ff <= nxt_blink;
         act_ff <= nxt_act;
         fl_ff <= nxt_fl;
         pause_ff <= nxt_pause;
         con_ff <= nxt_con;
         lk1_ff <= i_eth_link;
         lk2_ff <= lk1_ff;
         red_ff <= nxt_red;
         grn_ff <= nxt_grn;
         actl_ff <= (nxt_act == 2'h0);
         abort_ff <= i_mac_bad;
      end
   end
   assign o_link_led = lk2_ff;
   assign o_stat_red = red_ff;
   assign o_stat_grn = grn_ff;
   assign o_act_led = actl_ff;
   assign o_conn_led = con_ff;
   assign o_init_abort = abort_ff;

   // ***************************************************************
   // Checks
   // ***************************************************************
   property p_no_unsolicited;
      o_rsp_valid |-> pend_ff;
   endproperty
   a_no_unsolicited: assert property (p_no_unsolicited) else $error("reply without request");
   property p_port_only;
      take && (i_req_port != SRV_PORT) |=> st_ff == ST_IDLE;
   endproperty
   a_port_only: assert property (p_port_only) else $error("foreign port served");
   property p_conn_open;
      take && !i_conn_est[i_req_conn] |=> st_ff == ST_IDLE;
   endproperty
   a_conn_open: assert property (p_conn_open) else $error("closed link served");
   property p_ro_window;
      mif.a_we |-> (mif.a_addr >= AREA_WORDS) && (mif.a_addr < DATA_BYTES);
   endproperty
   a_ro_window: assert property (p_ro_window) else $error("write outside output area");
   property p_rd_ok;
      take_ok && (i_req_func == FN_RD) && (i_req_qty == 16'h0001) && (i_req_addr < WIN_REGS)
         ##1 i_ce |=> o_rsp_valid && !o_rsp_exc;
   endproperty
   a_rd_ok: assert property (p_rd_ok) else $error("legal read refused");
   property p_rd_data;
      (st_ff == ST_RD) && i_ce ##1 i_ce |=> o_rd_valid;
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read word missing");
   property p_exc_addr;
      o_rsp_valid && (func_ff == FN_WR1) && (addr_ff < OUT_BASE) |-> o_rsp_code == EXC_ADDR;
   endproperty
   a_exc_addr: assert property (p_exc_addr) else $error("read-only write accepted");
   property p_link;
      (i_eth_link && i_ce)[*3] |-> o_link_led;
   endproperty
   a_link: assert property (p_link) else $error("link lamp dark");
   property p_mac_red;
      i_mac_bad && i_ce |=> (o_stat_red == $past(blink_ff[2])) && !o_stat_grn && o_init_abort;
   endproperty
   a_mac_red: assert property (p_mac_red) else $error("bad MAC not shown");
   property p_flash;
      i_flash_fail && !i_mac_bad && i_ce |=> o_stat_red == $past(blink_ff[1]);
   endproperty
   a_flash: assert property (p_flash) else $error("flash fault rate wrong");
   property p_act;
      i_pkt_event && i_ce |=> !o_act_led;
   endproperty
   a_act: assert property (p_act) else $error("activity lamp not off");
   property p_conn_pause;
      (pause_ff != 4'h0) |-> !o_conn_led && (fl_ff == 4'h0);
   endproperty
   a_conn_pause: assert property (p_conn_pause) else $error("lamp lit in pause");
endmodule

/* File: mbs_pkg.sv */
package mbs_pkg;
   typedef logic [15:0] mbs_word_t;
   typedef logic [7:0] mbs_byte_t;
   typedef logic [2:0] mbs_conn_t;
   typedef logic [8:0] mbs_maddr_t;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_NS = 20;
   localparam int TICK_NS = 125_000_000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;

   // ***************************************************************
   // Protocol codes and windows
   // ***************************************************************
   localparam int CONN_N = 8;
   localparam logic [15:0] SRV_PORT = 16'h01F6;
   localparam logic [7:0] FN_RD = 8'h03;
   localparam logic [7:0] FN_WR1 = 8'h06;
   localparam logic [7:0] FN_WRN = 8'h10;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VAL = 8'h03;
   localparam logic [15:0] IN_BASE = 16'h0000;
   localparam logic [15:0] OUT_BASE = 16'h0400;
   localparam logic [15:0] WIN_REGS = 16'h00A1;
   localparam logic [15:0] MAX_RD_QTY = 16'h007D;
   localparam logic [15:0] MAX_WR_QTY = 16'h007B;
   localparam logic [8:0] DATA_BYTES = 9'h140;
   localparam logic [8:0] AREA_WORDS = 9'h0A0;

   // ***************************************************************
   // Indicator timing in 125 ms ticks
   // ***************************************************************
   localparam logic [1:0] ACT_OFF_TICKS = 2'h2;
   localparam logic [3:0] CONN_PAUSE_TICKS = 4'h8;

   typedef enum logic [4:0]
   {
      ST_IDLE = 5'h01,
      ST_CHK = 5'h02,
      ST_HDR = 5'h04,
      ST_RD = 5'h08,
      ST_WR = 5'h10
   } mbs_st_t;
endpackage

/* File: mbs_mem_if.sv */
`timescale 1ns/1ps
// Two ports into the shared data area: a for the server, b for instruments
interface mbs_mem_if;
   import mbs_pkg::*;
   logic a_we;
   logic [1:0] a_be;
   mbs_maddr_t a_addr;
   mbs_word_t a_wdata;
   mbs_word_t a_rdata;
   logic b_we;
   logic [1:0] b_be;
   mbs_maddr_t b_addr;
   mbs_word_t b_wdata;
   mbs_word_t b_rdata;
   modport srv (output a_we, a_be, a_addr, a_wdata, b_we, b_be, b_addr, b_wdata,
      input a_rdata, b_rdata);
   modport mem (input a_we, a_be, a_addr, a_wdata, b_we, b_be, b_addr, b_wdata,
      output a_rdata, b_rdata);
endinterface

/* File: mbs_dpram.sv */
`timescale 1ns/1ps
module mbs_dpram
#(
   parameter int DEPTH = 320,
   parameter int LANES = 2
)
(
   input wire logic i_mclk,
   input wire logic i_ce,
   mbs_mem_if.mem port
);
   import mbs_pkg::*;

   // ***************************************************************
   // Storage, one byte lane per array slice
   // ***************************************************************
   logic [7:0] ram [DEPTH][LANES];
   mbs_word_t ra_ff;
   mbs_word_t rb_ff;

   // Both ports may write; callers keep them on disjoint windows
   always_ff @(posedge i_mclk)
   begin
      if (i_ce)
      begin
         for (int l = 0; l < LANES; l++)
         begin
            if (port.a_we && port.a_be[l])
               ram[port.a_addr][l] <= port.a_wdata[8*l +: 8];
            if (port.b_we && port.b_be[l])
               ram[port.b_addr][l] <= port.b_wdata[8*l +: 8];
            ra_ff[8*l +: 8] <= ram[port.a_addr][l];
            rb_ff[8*l +: 8] <= ram[port.b_addr][l];
         end
      end
   end

   // Registered read data
   assign port.a_rdata = ra_ff;
   assign port.b_rdata = rb_ff;
endmodule

/* File: mbs_master_model.sv */
`timescale 1ns/1ps
// Remote master: one request at a time, feeds write words, gathers the reply
module mbs_master_model
(
   input wire logic i_mclk,
   input wire logic i_req_ready,
   input wire logic i_wr_ready,
   input wire logic i_rsp_valid,
   input wire logic i_rd_valid,
   input wire mbs_pkg::mbs_word_t i_rd_word,
   output logic o_req_valid,
   output mbs_pkg::mbs_conn_t o_req_conn,
   output mbs_pkg::mbs_word_t o_req_port,
   output mbs_pkg::mbs_byte_t o_req_func,
   output mbs_pkg::mbs_word_t o_req_addr,
   output mbs_pkg::mbs_word_t o_req_qty,
   output logic o_wr_valid,
   output mbs_pkg::mbs_word_t o_wr_word
);
   import mbs_pkg::*;
   mbs_word_t wd [0:3];
   mbs_word_t rd [0:3];
   logic got_rsp;

   // Quiet lines at time zero
   initial
   begin
      o_req_valid = 1'b0;
      o_wr_valid = 1'b0;
      {o_req_conn, o_req_port, o_req_func, o_req_addr, o_req_qty, o_wr_word} = '0;
   end

   // Offer until taken, then over a fixed span stream words and watch for the reply
   task automatic xfer(input mbs_conn_t c, input mbs_word_t p, input mbs_byte_t f,
      input mbs_word_t a, input mbs_word_t q, input int nw);
      int i;
      int n;
      i = 0;
      n = 0;
      got_rsp = 1'b0;
      foreach (rd[k])
         rd[k] = 16'h0000;
      @(posedge i_mclk);
      o_req_valid <= 1'b1;
      o_req_conn <= c;
      o_req_port <= p;
      o_req_func <= f;
      o_req_addr <= a;
      o_req_qty <= q;
      do
         @(posedge i_mclk);
      while (!i_req_ready);
      // Released address and count change, so a stale value never looks valid
      o_req_valid <= 1'b0;
      o_req_addr <= ~a;
      o_req_qty <= ~q;
      o_wr_valid <= (nw > 0);
      o_wr_word <= wd[0];
      repeat (14)
      begin
         @(posedge i_mclk);
         if (o_wr_valid && i_wr_ready)
            i++;
         if (i_rsp_valid)
            got_rsp = 1'b1;
         if (i_rd_valid && n < 4)
         begin
            rd[n] = i_rd_word;
            n++;
         end
         o_wr_valid <= (i < nw);
         o_wr_word <= (i < nw && i < 4) ? wd[i] : ~o_wr_word;
      end
   endtask
endmodule

/* File: modbus_tcp_register_server_bench.sv */
`timescale 1ns/1ps
module modbus_tcp_register_server_bench;
   import mbs_pkg::*;
   logic i_mclk, i_reset_n, rq_v, rq_rdy, wr_v, wr_rdy, rsp_v, rsp_exc, rd_v, iwe, ire, irv;
   logic pkt, link, ipnd, macb, flash, fault, l_link, l_red, l_grn, l_act, l_conn, abrt;
   logic [7:0] est;
   mbs_conn_t rq_c, rsp_c;
   mbs_word_t rq_p, rq_a, rq_q, wr_w, rsp_q, rd_w;
   mbs_byte_t rq_f, rsp_f, rsp_code, iwd, ird;
   mbs_maddr_t ia;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;

   // ********
   // Design and remote master; short tick keeps lamp runs brief
   // ********
   mbs_server #(.TICK_CYCLES(4)) i_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(1'b1),
      .i_req_valid(rq_v), .o_req_ready(rq_rdy), .i_req_conn(rq_c), .i_req_port(rq_p),
      .i_req_func(rq_f), .i_req_addr(rq_a), .i_req_qty(rq_q), .i_wr_valid(wr_v),
      .o_wr_ready(wr_rdy), .i_wr_word(wr_w), .o_rsp_valid(rsp_v), .o_rsp_conn(rsp_c),
      .o_rsp_func(rsp_f), .o_rsp_exc(rsp_exc), .o_rsp_code(rsp_code), .o_rsp_qty(rsp_q),
      .o_rd_valid(rd_v), .o_rd_word(rd_w), .i_inst_we(iwe), .i_inst_re(ire), .i_inst_addr(ia),
      .i_inst_wdata(iwd), .o_inst_rvalid(irv), .o_inst_rdata(ird), .i_conn_est(est),
      .i_pkt_event(pkt), .i_eth_link(link), .i_ip_not_dip(ipnd), .i_mac_bad(macb),
      .i_flash_fail(flash), .i_int_fault(fault), .o_link_led(l_link), .o_stat_red(l_red),
      .o_stat_grn(l_grn), .o_act_led(l_act), .o_conn_led(l_conn), .o_init_abort(abrt));
   mbs_master_model i_mst (.i_mclk(i_mclk), .i_req_ready(rq_rdy), .i_wr_ready(wr_rdy),
      .i_rsp_valid(rsp_v), .i_rd_valid(rd_v), .i_rd_word(rd_w), .o_req_valid(rq_v),
      .o_req_conn(rq_c), .o_req_port(rq_p), .o_req_func(rq_f), .o_req_addr(rq_a),
      .o_req_qty(rq_q), .o_wr_valid(wr_v), .o_wr_word(wr_w));

   // Clock at 50 MHz
   initial
   begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end

   // Hang guard, far above the run length
   always @(posedge i_mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         finish_test();
      end
   end

   // ********
   // Helpers
   // ********
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Blink counts vary by one with the phase at which counting starts
   task automatic near(input string nm, input int e, input int g);
      chk(nm, 16'(e), (g >= e - 1 && g <= e + 1) ? 16'(e) : 16'(g));
   endtask

   task automatic ck_rsp(input mbs_byte_t code);
      chk("reply", 16'h0001, {15'h0000, i_mst.got_rsp});
      chk("code", {8'h00, code}, {8'h00, rsp_code});
      chk("exc", {15'h0000, code != EXC_NONE}, {15'h0000, rsp_exc});
   endtask

   task automatic inst_wr(input mbs_maddr_t a, input mbs_byte_t d);
      @(posedge i_mclk);
      iwe <= 1'b1;
      ia <= a;
      iwd <= d;
      @(posedge i_mclk);
      iwe <= 1'b0;
      iwd <= ~d;
   endtask

   task automatic inst_rd(input mbs_maddr_t a, output mbs_byte_t d);
      @(posedge i_mclk);
      ire <= 1'b1;
      ia <= a;
      @(posedge i_mclk);
      ire <= 1'b0;
      for (int k = 0; k < 4 && !irv; k++)
         @(posedge i_mclk);
      d = irv ? ird : 8'h00;
   endtask

   // Counts red and green changes and connection flashes over 28 ticks
   task automatic tog(output int r, output int g, output int c);
      logic pr;
      logic pg;
      logic pc;
      r = 0;
      g = 0;
      c = 0;
      pr = l_red;
      pg = l_grn;
      pc = l_conn;
      repeat (112)
      begin
         @(posedge i_mclk);
         r += int'(l_red != pr);
         g += int'(l_grn != pg);
         c += int'(l_conn && !pc);
         pr = l_red;
         pg = l_grn;
         pc = l_conn;
      end
   endtask

   // ********
   // Scenarios
   // ********
   task s_read_in;
      for (int k = 0; k < 4; k++)
         inst_wr(9'(k), 8'(8'h12 + 8'h22 * k));
      i_mst.xfer(3'h5, SRV_PORT, FN_RD, IN_BASE, 16'h0002, 0);
      ck_rsp(EXC_NONE);
      chk("conn", 16'h0005, {13'h0000, rsp_c});
      chk("func", {8'h00, FN_RD}, {8'h00, rsp_f});
      chk("qty", 16'h0002, rsp_q);
      chk("in0", 16'h1234, i_mst.rd[0]);
      chk("in1", 16'h5678, i_mst.rd[1]);
   endtask

   task s_write;
      mbs_byte_t b;
      i_mst.wd[0] = 16'hA1B2;
      i_mst.wd[1] = 16'hC3D4;
      i_mst.xfer(3'h7, SRV_PORT, FN_WRN, OUT_BASE, 16'h0002, 2);
      ck_rsp(EXC_NONE);
      chk("wqty", 16'h0002, rsp_q);
      i_mst.wd[0] = 16'h5A5A;
      i_mst.xfer(3'h7, SRV_PORT, FN_WR1, OUT_BASE + 16'h0001, 16'h0001, 1);
      ck_rsp(EXC_NONE);
      chk("qty1", 16'h0001, rsp_q);
      i_mst.xfer(3'h0, SRV_PORT, FN_RD, OUT_BASE, 16'h0002, 0);
      chk("back0", 16'hA1B2, i_mst.rd[0]);
      chk("back1", 16'h5A5A, i_mst.rd[1]);
      inst_rd(9'h000, b);
      chk("out_b0", 16'h00A1, {8'h00, b});
      inst_rd(9'h003, b);
      chk("out_b3", 16'h005A, {8'h00, b});
   endtask

   // Writes into the read-only window, stray addresses, a zero count, other codes
   task s_refuse;
      mbs_byte_t fn [0:13] = '{8'h06, 8'h10, 8'h03, 8'h03, 8'h03, 8'h03, 8'h01, 8'h02,
         8'h04, 8'h05, 8'h07, 8'h0F, 8'h16, 8'h17};
      mbs_word_t ad [0:4] = '{16'h0000, 16'h0000, 16'h00A1, 16'h00A0, 16'h03FF};
      i_mst.wd[0] = 16'hFFFF;
      for (int k = 0; k < 14; k++)
      begin
         i_mst.xfer(3'h1, SRV_PORT, fn[k], (k < 5) ? ad[k] : 16'h0000,
            (k == 3) ? 16'h0002 : (k == 5) ? 16'h0000 : 16'h0001, 1);
         ck_rsp((k < 5) ? EXC_ADDR : (k == 5) ? EXC_VAL : EXC_FUNC);
      end
      i_mst.xfer(3'h1, SRV_PORT, FN_RD, IN_BASE, 16'h0001, 0);
      chk("ro_kept", 16'h1234, i_mst.rd[0]);
      i_mst.xfer(3'h1, SRV_PORT, FN_RD, IN_BASE + 16'h00A0, 16'h0001, 0);
      chk("past_end", 16'h0000, i_mst.rd[0]);
   endtask

   task s_drop;
      i_mst.xfer(3'h1, 16'h01F7, FN_RD, IN_BASE, 16'h0001, 0);
      chk("port", 16'h0000, {15'h0000, i_mst.got_rsp});
      i_mst.xfer(3'h6, SRV_PORT, FN_RD, IN_BASE, 16'h0001, 0);
      chk("closed", 16'h0000, {15'h0000, i_mst.got_rsp});
   endtask

   task s_lamps;
      int r;
      int g;
      int c;
      @(posedge i_mclk);
      link <= 1'b1;
      pkt <= 1'b1;
      @(posedge i_mclk);
      pkt <= 1'b0;
      repeat (3) @(posedge i_mclk);
      chk("act_off", 16'h0000, {15'h0000, l_act});
      repeat (16) @(posedge i_mclk);
      chk("act_on", 16'h0001, {15'h0000, l_act});
      chk("link_on", 16'h0001, {15'h0000, l_link});
      link <= 1'b0;
      est <= 8'h07;
      fault <= 1'b1;
      repeat (8) @(posedge i_mclk);
      chk("link_off", 16'h0000, {15'h0000, l_link});
      tog(r, g, c);
      near("red4", 28, r);
      near("conn", 6, c);
      flash <= 1'b1;
      repeat (2) @(posedge i_mclk);
      tog(r, g, c);
      near("red2", 14, r);
      macb <= 1'b1;
      repeat (2) @(posedge i_mclk);
      tog(r, g, c);
      near("red1", 7, r);
      chk("abort", 16'h0001, {15'h0000, abrt});
      {macb, flash, fault} <= 3'h0;
      ipnd <= 1'b1;
      repeat (2) @(posedge i_mclk);
      tog(r, g, c);
      near("grn1", 7, g);
      chk("red_off", 16'h0000, 16'(r));
      ipnd <= 1'b0;
      repeat (2) @(posedge i_mclk);
      chk("grn_on", 16'h0001, {15'h0000, l_grn});
   endtask

   // ********
   // Main sequence
   // ********
   initial
   begin
      i_reset_n = 1'b0;
      {iwe, ire, pkt, link, ipnd, macb, flash, fault} = '0;
      ia = '0;
      iwd = '0;
      est = 8'hBF;
      repeat (16) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      repeat (5) @(posedge i_mclk);
      s_read_in();
      s_write();
      s_refuse();
      s_drop();
      s_lamps();
      finish_test();
   end
endmodule
